/* hw/sro_consts.svh */
// sro_consts.svh: register offsets, field positions, reset values and counts
// assumes: included by bare name from the design modules, the monitor and the bench
`ifndef SRO_CONSTS_SVH
`define SRO_CONSTS_SVH

// ==========================================================
// device register map (12-bit configuration address, 8-bit data)
`define SRO_OFS_SOFT_RESET 12'h000
`define SRO_OFS_SYNC_LIMIT 12'h210
`define SRO_OFS_OVR_LEVEL 12'h211
`define SRO_OFS_OVR_CONFIG 12'h213
`define SRO_OFS_STARTUP 12'h270
`define SRO_OFS_POWER2 12'h29A
`define SRO_OFS_IRQ_STATUS 12'h2F0
`define SRO_OFS_IRQ_MASK 12'h2F1
`define SRO_OFS_LINK_EN 12'h2F2

// ==========================================================
// reset values and writable-bit masks
`define SRO_RST_SYNC_LIMIT 5'h03
`define SRO_RST_OVR_LEVEL 8'hF2
`define SRO_RST_OVR_EXP 3'h7
`define SRO_RST_POWER2 8'h0F
`define SRO_MASK_SYNC_LIMIT 8'h1F
`define SRO_MASK_OVR_CONFIG 8'h0F
`define SRO_MASK_ONE_BIT 8'h01
`define SRO_MASK_IRQ 8'h07
`define SRO_MASK_FULL 8'hFF

// ==========================================================
// field positions
`define SRO_BIT_OVR_ON 3
`define SRO_BIT_SOFT_RESET 0
`define SRO_BIT_INIT_DONE 0
`define SRO_IRQ_SYNC 0
`define SRO_IRQ_OVR 1
`define SRO_IRQ_INIT 2

// ==========================================================
// counts
`define SRO_INIT_CYCLES 8'h40
`define SRO_STRETCH_BASE 10'h004
`define SRO_SYNC_CNT_MAX 6'h3F

// ==========================================================
// host command port (word offsets)
`define SRO_H_ADDR 4'h0
`define SRO_H_WDATA 4'h1
`define SRO_H_CMD 4'h2
`define SRO_H_STATUS 4'h3
`define SRO_H_RDATA 4'h4
`define SRO_H_SYNC_LEN 4'h5
`define SRO_H_CMD_WR 0
`define SRO_H_CMD_RD 1
`define SRO_H_CMD_SYNC 2

`endif

/* hw/sro_pkg.sv */
// sro_pkg.sv: shared types of the sync request and over-range monitor
// assumes: constants come from sro_consts.svh
package sro_pkg;
  typedef logic [11:0] sro_addr_t;
  typedef logic [7:0] sro_byte_t;
  typedef logic signed [11:0] sro_sample_t;
  typedef enum logic [2:0] {
    SRO_H_POLL,
    SRO_H_POLL_WAIT,
    SRO_H_THRESH,
    SRO_H_IDLE,
    SRO_H_READ_WAIT
  } sro_host_state_t;
endpackage

/* hw/sro_link_if.sv */
// sro_link_if.sv: configuration port, sync request line and over-range pins
// assumes: both ends share one clock; the testbench instantiates it
`timescale 1ns/1ps
interface sro_link_if;
  logic [11:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic cfg_wr;
  logic cfg_rd;
  logic [7:0] cfg_rdata;
  logic sync_n;
  logic overrange_out_a;
  logic overrange_out_b;
  logic overrange_out_c;
  logic overrange_out_d;

  modport dev (
    input cfg_addr, cfg_wdata, cfg_wr, cfg_rd, sync_n,
    output cfg_rdata, overrange_out_a, overrange_out_b, overrange_out_c, overrange_out_d
  );
  modport host (
    output cfg_addr, cfg_wdata, cfg_wr, cfg_rd, sync_n,
    input cfg_rdata, overrange_out_a, overrange_out_b, overrange_out_c, overrange_out_d
  );
endinterface

/* hw/sro_device.sv */
// sro_device.sv: converter-side sync request qualifier, over-range pins,
// startup flag and configuration registers
// assumes: one clock shared with the far end, synchronous active-high reset
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "sro_consts.svh"

// How it works
// - sync request after threshold plus one lows
// - sync line sampled on the link clock
// - shorter low bursts are error reports, ignored
// - host changes threshold only with link disabled
// - host programs threshold zero for fastest response
// - over-range when sample magnitude reaches level
// - over-range pins held low unless enabled
// - pulses stretched to four times two-to-exponent
// - startup bit reads one once init finishes
// - host waits for startup except soft reset
// - host writes reserved bits as zero
module sro_device (
  // link to the far end
  sro_link_if.dev link,
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // converter samples, channel a in slot 0
  input wire logic [3:0][11:0] sample,
  // events
  output logic sync_request,
  output logic irq
);

  // ==========================================================
  // register state
  logic [4:0] sync_limit_reg;
  logic [7:0] ovr_level_reg;
  logic ovr_on_reg;
  logic [2:0] ovr_exp_reg;
  logic [7:0] power2_reg;
  logic link_en_reg;
  logic [2:0] irq_status_reg;
  logic [2:0] irq_mask_reg;
  logic [7:0] rdata_reg;
  logic [7:0] init_cnt_reg;
  logic init_done_reg;
  logic irq_reg;

  // ==========================================================
  // write decode
  wire soft_rst = link.cfg_wr && link.cfg_addr == `SRO_OFS_SOFT_RESET
    && link.cfg_wdata[`SRO_BIT_SOFT_RESET];
  wire any_rst = rst || soft_rst;
  wire wr_thresh = link.cfg_wr && link.cfg_addr == `SRO_OFS_SYNC_LIMIT;
  wire wr_level = link.cfg_wr && link.cfg_addr == `SRO_OFS_OVR_LEVEL;
  wire wr_config = link.cfg_wr && link.cfg_addr == `SRO_OFS_OVR_CONFIG;
  wire wr_power2 = link.cfg_wr && link.cfg_addr == `SRO_OFS_POWER2;
  wire wr_mask = link.cfg_wr && link.cfg_addr == `SRO_OFS_IRQ_MASK;
  wire wr_link_en = link.cfg_wr && link.cfg_addr == `SRO_OFS_LINK_EN;
  wire rd_status = link.cfg_rd && link.cfg_addr == `SRO_OFS_IRQ_STATUS;

  always_ff @(posedge clk) begin
    if (any_rst) begin
      sync_limit_reg <= `SRO_RST_SYNC_LIMIT;
      ovr_level_reg <= `SRO_RST_OVR_LEVEL;
      ovr_on_reg <= 1'b0;
      ovr_exp_reg <= `SRO_RST_OVR_EXP;
      power2_reg <= `SRO_RST_POWER2;
      link_en_reg <= 1'b0;
      irq_mask_reg <= 3'h0;
    end else begin
      if (wr_thresh) begin
        sync_limit_reg <= link.cfg_wdata[4:0];
      end
      if (wr_level) begin
        ovr_level_reg <= link.cfg_wdata;
      end
      if (wr_config) begin
        ovr_on_reg <= link.cfg_wdata[`SRO_BIT_OVR_ON];
        ovr_exp_reg <= link.cfg_wdata[2:0];
      end
      if (wr_power2) begin
        power2_reg <= link.cfg_wdata;
      end
      if (wr_mask) begin
        irq_mask_reg <= link.cfg_wdata[2:0];
      end
      if (wr_link_en) begin
        link_en_reg <= link.cfg_wdata[0];
      end
    end
  end

  // ==========================================================
  // read mux; reserved bits and unmapped addresses read zero
  logic [7:0] rd_value;
  always_comb begin
    rd_value = 8'h00;
    if (link.cfg_addr == `SRO_OFS_SYNC_LIMIT) begin
      rd_value = {3'h0, sync_limit_reg};
    end else if (link.cfg_addr == `SRO_OFS_OVR_LEVEL) begin
      rd_value = ovr_level_reg;
    end else if (link.cfg_addr == `SRO_OFS_OVR_CONFIG) begin
      rd_value = {4'h0, ovr_on_reg, ovr_exp_reg};
    end else if (link.cfg_addr == `SRO_OFS_STARTUP) begin
      rd_value = {7'h00, init_done_reg};
    end else if (link.cfg_addr == `SRO_OFS_POWER2) begin
      rd_value = power2_reg;
    end else if (link.cfg_addr == `SRO_OFS_IRQ_STATUS) begin
      rd_value = {5'h00, irq_status_reg};
    end else if (link.cfg_addr == `SRO_OFS_IRQ_MASK) begin
      rd_value = {5'h00, irq_mask_reg};
    end else if (link.cfg_addr == `SRO_OFS_LINK_EN) begin
      rd_value = {7'h00, link_en_reg};
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= link.cfg_rd ? rd_value : 8'h00;
    end
  end
  assign link.cfg_rdata = rdata_reg;

  // ==========================================================
  // startup sequencer: a fixed settle count stands in for real init work
  wire init_finish = !init_done_reg && init_cnt_reg == `SRO_INIT_CYCLES;
  always_ff @(posedge clk) begin
    if (any_rst) begin
      init_cnt_reg <= 8'h00;
      init_done_reg <= 1'b0;
    end else begin
      if (!init_done_reg) begin
        init_cnt_reg <= init_cnt_reg + 8'h01;
      end
      if (init_finish) begin
        init_done_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // sync request qualifier
  // the line is treated as a pin, so two flops come before any logic
  logic sync_meta_reg;
  logic sync_line_reg;
  logic [5:0] low_cnt_reg;
  logic sync_request_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_meta_reg <= 1'b1;
      sync_line_reg <= 1'b1;
    end else begin
      sync_meta_reg <= link.sync_n;
      sync_line_reg <= sync_meta_reg;
    end
  end

  wire sync_low = !sync_line_reg;
  // low_cnt holds the lows seen before this one, so reaching the
  // threshold means threshold plus one consecutive lows
  wire sync_qualified = sync_low && low_cnt_reg >= {1'b0, sync_limit_reg};
  wire sync_event = sync_low && low_cnt_reg == {1'b0, sync_limit_reg};
  wire [5:0] low_cnt_next = !sync_low ? 6'h00
    : (low_cnt_reg == `SRO_SYNC_CNT_MAX) ? low_cnt_reg : low_cnt_reg + 6'h01;

  always_ff @(posedge clk) begin
    if (any_rst) begin
      low_cnt_reg <= 6'h00;
      sync_request_reg <= 1'b0;
    end else begin
      low_cnt_reg <= low_cnt_next;
      // a short burst never qualifies and leaves no trace
      sync_request_reg <= sync_qualified;
    end
  end
  assign sync_request = sync_request_reg;

  // ==========================================================
  // over-range detectors, one per channel
  function automatic logic [9:0] stretch_len(input logic [2:0] exp);
    stretch_len = `SRO_STRETCH_BASE << exp;
  endfunction

  logic [3:0] ovr_reg;
  logic [3:0] ovr_hit;
  wire [9:0] stretch = stretch_len(ovr_exp_reg);
  // level/256 of full scale equals level*8 in 12-bit magnitude
  wire [11:0] level_mag = {1'b0, ovr_level_reg, 3'h0};

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_ch
      logic [9:0] hold_reg;
      wire [11:0] mag = sample[ch][11] ? 12'(-sample[ch]) : sample[ch];
      assign ovr_hit[ch] = mag >= level_mag;
      always_ff @(posedge clk) begin
        if (any_rst) begin
          hold_reg <= 10'h000;
          ovr_reg[ch] <= 1'b0;
        end else begin
          // a hit restarts the window so the pulse lasts at least stretch
          hold_reg <= !ovr_on_reg ? 10'h000 : ovr_hit[ch] ? stretch - 10'h001
            : (hold_reg != 10'h000) ? hold_reg - 10'h001 : hold_reg;
          ovr_reg[ch] <= ovr_on_reg && (ovr_hit[ch] || hold_reg != 10'h000);
        end
      end
    end
  endgenerate

  assign link.overrange_out_a = ovr_reg[0];
  assign link.overrange_out_b = ovr_reg[1];
  assign link.overrange_out_c = ovr_reg[2];
  assign link.overrange_out_d = ovr_reg[3];

  // ==========================================================
  // interrupts: sticky, read clears, a new event wins over the clear
  logic [3:0] ovr_prev_reg;
  wire ovr_rise = |(ovr_reg & ~ovr_prev_reg);
  wire [2:0] irq_events = {init_finish, ovr_rise, sync_event};
  wire [2:0] irq_status_next = (rd_status ? 3'h0 : irq_status_reg) | irq_events;

  always_ff @(posedge clk) begin
    if (any_rst) begin
      ovr_prev_reg <= 4'h0;
      irq_status_reg <= 3'h0;
      irq_reg <= 1'b0;
    end else begin
      ovr_prev_reg <= ovr_reg;
      irq_status_reg <= irq_status_next;
      irq_reg <= |(irq_status_next & irq_mask_reg);
    end
  end
  assign irq = irq_reg;

endmodule // sro_device

/* hw/sro_host.sv */
// sro_host.sv: receiver-side controller that drives the configuration port
// and the sync request line on orders from software
// assumes: same clock as the device; software uses the plain command port
`timescale 1ns/1ps
`include "sro_consts.svh"

module sro_host (
  // link to the device
  sro_link_if.host link,
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // software command port
  input wire logic [3:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata
);

  // ==========================================================
  // state
  sro_pkg::sro_host_state_t state_reg;
  logic [11:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] sync_len_reg;
  logic [7:0] sync_cnt_reg;
  logic [7:0] last_rdata_reg;
  logic pend_wr_reg;
  logic pend_rd_reg;
  logic init_seen_reg;
  logic link_en_reg;
  logic refused_reg;
  logic [11:0] cfg_addr_reg;
  logic [7:0] cfg_wdata_reg;
  logic cfg_wr_reg;
  logic cfg_rd_reg;
  logic sync_n_reg;
  logic [15:0] sw_rdata_reg;

  // writable bits per address; reserved bits always go out as zero
  function automatic logic [7:0] write_mask(input logic [11:0] a);
    if (a == `SRO_OFS_SYNC_LIMIT) begin
      write_mask = `SRO_MASK_SYNC_LIMIT;
    end else if (a == `SRO_OFS_OVR_CONFIG) begin
      write_mask = `SRO_MASK_OVR_CONFIG;
    end else if (a == `SRO_OFS_IRQ_MASK) begin
      write_mask = `SRO_MASK_IRQ;
    end else if (a == `SRO_OFS_LINK_EN || a == `SRO_OFS_SOFT_RESET) begin
      write_mask = `SRO_MASK_ONE_BIT;
    end else begin
      write_mask = `SRO_MASK_FULL;
    end
  endfunction

  // ==========================================================
  // command decode
  wire cmd_wr = sw_wr && sw_addr == `SRO_H_CMD;
  wire pend_soft = pend_wr_reg && addr_reg == `SRO_OFS_SOFT_RESET;
  wire block_thresh = addr_reg == `SRO_OFS_SYNC_LIMIT && link_en_reg;
  wire [7:0] wr_value = wdata_reg & write_mask(addr_reg);
  wire [7:0] sync_cnt_next = (cmd_wr && sw_wdata[`SRO_H_CMD_SYNC]) ? sync_len_reg
    : (sync_cnt_reg != 8'h00) ? sync_cnt_reg - 8'h01 : sync_cnt_reg;
  wire [3:0] ovr_pins = {link.overrange_out_d, link.overrange_out_c, link.overrange_out_b,
    link.overrange_out_a};

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= sro_pkg::SRO_H_POLL;
      addr_reg <= 12'h000;
      wdata_reg <= 8'h00;
      sync_len_reg <= 8'h00;
      sync_cnt_reg <= 8'h00;
      last_rdata_reg <= 8'h00;
      pend_wr_reg <= 1'b0;
      pend_rd_reg <= 1'b0;
      init_seen_reg <= 1'b0;
      link_en_reg <= 1'b0;
      refused_reg <= 1'b0;
      cfg_addr_reg <= 12'h000;
      cfg_wdata_reg <= 8'h00;
      cfg_wr_reg <= 1'b0;
      cfg_rd_reg <= 1'b0;
      sync_n_reg <= 1'b1;
      sw_rdata_reg <= 16'h0000;
    end else begin
      cfg_wr_reg <= 1'b0;
      cfg_rd_reg <= 1'b0;
      sync_cnt_reg <= sync_cnt_next;
      sync_n_reg <= sync_cnt_next == 8'h00;
      sw_rdata_reg <= 16'h0000;
      if (sw_wr && sw_addr == `SRO_H_ADDR) begin
        addr_reg <= sw_wdata[11:0];
      end
      if (sw_wr && sw_addr == `SRO_H_WDATA) begin
        wdata_reg <= sw_wdata[7:0];
      end
      if (sw_wr && sw_addr == `SRO_H_SYNC_LEN) begin
        sync_len_reg <= sw_wdata[7:0];
      end
      if (cmd_wr && sw_wdata[`SRO_H_CMD_WR]) begin
        pend_wr_reg <= 1'b1;
      end
      if (cmd_wr && sw_wdata[`SRO_H_CMD_RD]) begin
        pend_rd_reg <= 1'b1;
      end
      if (sw_rd && sw_addr == `SRO_H_STATUS) begin
        sw_rdata_reg <= {9'h000, ovr_pins, refused_reg, init_seen_reg,
          state_reg != sro_pkg::SRO_H_IDLE || pend_wr_reg || pend_rd_reg};
        refused_reg <= 1'b0;
      end else if (sw_rd && sw_addr == `SRO_H_RDATA) begin
        sw_rdata_reg <= {8'h00, last_rdata_reg};
      end
      case (state_reg)
        sro_pkg::SRO_H_POLL: begin
          cfg_wdata_reg <= wr_value;
          if (pend_soft) begin
            cfg_addr_reg <= addr_reg;
            cfg_wr_reg <= 1'b1;
            pend_wr_reg <= 1'b0;
          end else begin
            cfg_addr_reg <= `SRO_OFS_STARTUP;
            cfg_rd_reg <= 1'b1;
            state_reg <= sro_pkg::SRO_H_POLL_WAIT;
          end
        end
        sro_pkg::SRO_H_POLL_WAIT: begin
          if (!cfg_rd_reg) begin
            state_reg <= link.cfg_rdata[`SRO_BIT_INIT_DONE] ? sro_pkg::SRO_H_THRESH
              : sro_pkg::SRO_H_POLL;
          end
        end
        sro_pkg::SRO_H_THRESH: begin
          cfg_addr_reg <= `SRO_OFS_SYNC_LIMIT;
          cfg_wdata_reg <= 8'h00;
          cfg_wr_reg <= 1'b1;
          init_seen_reg <= 1'b1;
          state_reg <= sro_pkg::SRO_H_IDLE;
        end
        sro_pkg::SRO_H_IDLE: begin
          cfg_addr_reg <= addr_reg;
          cfg_wdata_reg <= wr_value;
          if (pend_wr_reg) begin
            pend_wr_reg <= 1'b0;
            if (block_thresh) begin
              refused_reg <= 1'b1;
            end else begin
              cfg_wr_reg <= 1'b1;
              if (addr_reg == `SRO_OFS_LINK_EN) begin
                link_en_reg <= wr_value[0];
              end
              if (pend_soft && wr_value[`SRO_BIT_SOFT_RESET]) begin
                // device restarts its init, so wait for it again
                init_seen_reg <= 1'b0;
                link_en_reg <= 1'b0;
                state_reg <= sro_pkg::SRO_H_POLL;
              end
            end
          end else if (pend_rd_reg) begin
            pend_rd_reg <= 1'b0;
            cfg_rd_reg <= 1'b1;
            state_reg <= sro_pkg::SRO_H_READ_WAIT;
          end
        end
        sro_pkg::SRO_H_READ_WAIT: begin
          if (!cfg_rd_reg) begin
            last_rdata_reg <= link.cfg_rdata;
            state_reg <= sro_pkg::SRO_H_IDLE;
          end
        end
        default: begin
          state_reg <= sro_pkg::SRO_H_POLL;
        end
      endcase
    end
  end

  assign link.cfg_addr = cfg_addr_reg;
  assign link.cfg_wdata = cfg_wdata_reg;
  assign link.cfg_wr = cfg_wr_reg;
  assign link.cfg_rd = cfg_rd_reg;
  assign link.sync_n = sync_n_reg;
  assign sw_rdata = sw_rdata_reg;

endmodule // sro_host

/* verif/sro_monitor.sv */
// sro_monitor.sv: assertions on the link between host and device
// assumes: instanced once in tb_top beside the link interface, one clock
`timescale 1ns/1ps
`include "sro_consts.svh"
// ==========================================================
// link checker
module sro_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration port
  input wire logic [11:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_rdata,
  // sync line and over-range pins
  input wire logic sync_n,
  input wire logic sync_request,
  input wire logic overrange_out_a,
  input wire logic overrange_out_b,
  input wire logic overrange_out_c,
  input wire logic overrange_out_d
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [4:0] thr_reg;
  logic [7:0] lvl_reg;
  logic [3:0] ocfg_reg;
  logic link_reg;
  logic done_reg;
  logic rdi_reg;
  logic [5:0] low_reg;
  logic [2:0] qd_reg;
  logic [10:0] hi_reg;
  logic [7:0] init_reg;
  wire wr_thr = cfg_wr && cfg_addr == `SRO_OFS_SYNC_LIMIT;
  wire wr_cfg = cfg_wr && cfg_addr == `SRO_OFS_OVR_CONFIG;
  wire rd_init = cfg_rd && cfg_addr == `SRO_OFS_STARTUP;
  wire qual = low_reg > {1'b0, thr_reg};
  wire [3:0] pins = {overrange_out_d, overrange_out_c, overrange_out_b, overrange_out_a};
  wire is_thr = cfg_addr == `SRO_OFS_SYNC_LIMIT;
  wire is_lvl = cfg_addr == `SRO_OFS_OVR_LEVEL;
  wire known = is_thr || is_lvl || cfg_addr == `SRO_OFS_OVR_CONFIG;
  wire [7:0] exp_rd = is_thr ? {3'h0, thr_reg} : is_lvl ? lvl_reg : {4'h0, ocfg_reg};
  // shadow of the device registers as seen on the wire
  always_ff @(posedge clk) begin
    if (rst) begin
      thr_reg <= `SRO_RST_SYNC_LIMIT;
      lvl_reg <= `SRO_RST_OVR_LEVEL;
      ocfg_reg <= {1'b0, `SRO_RST_OVR_EXP};
      link_reg <= 1'b0;
      done_reg <= 1'b0;
      rdi_reg <= 1'b0;
      low_reg <= 6'h00;
      qd_reg <= 3'h0;
      hi_reg <= 11'h000;
      init_reg <= 8'h00;
    end else begin
      if (wr_thr) thr_reg <= cfg_wdata[4:0];
      if (cfg_wr && is_lvl) lvl_reg <= cfg_wdata;
      if (wr_cfg) ocfg_reg <= cfg_wdata[3:0];
      if (cfg_wr && cfg_addr == `SRO_OFS_LINK_EN) link_reg <= cfg_wdata[0];
      rdi_reg <= rd_init;
      done_reg <= done_reg || (rdi_reg && cfg_rdata[0]);
      low_reg <= sync_n ? 6'h00 : (low_reg == `SRO_SYNC_CNT_MAX) ? low_reg : low_reg + 6'h01;
      qd_reg <= {qd_reg[1:0], qual};
      hi_reg <= overrange_out_a ? hi_reg + 11'h001 : 11'h000;
      init_reg <= (init_reg == 8'hFF) ? init_reg : init_reg + 8'h01;
    end
  end
  // ==========================================================
  // assertions
  sequence s_zero_written;
    wr_thr && cfg_wdata == 8'h00;
  endsequence
  a_sync_rise: assert property ($rose(qual) |-> ##[2:3] sync_request)
    else $error("sync request not raised after qualifying lows");
  a_sync_ignored: assert property (!qual && qd_reg == 3'h0 |-> !sync_request)
    else $error("sync request raised by a short low burst");
  a_pins_off: assert property (!ocfg_reg[3] && !$past(ocfg_reg[3]) |-> pins == 4'h0)
    else $error("over-range pin high while disabled");
  a_hold_min: assert property ($fell(overrange_out_a) && ocfg_reg[3] && $past(ocfg_reg[3]) |->
    hi_reg >= (11'h004 << ocfg_reg[2:0]))
    else $error("over-range pulse shorter than the hold time");
  a_startup_early: assert property (rd_init && init_reg < 8'h3C |=> cfg_rdata == 8'h00)
    else $error("startup bit set too early");
  a_startup_late: assert property (rd_init && init_reg == 8'hFF |=> cfg_rdata == 8'h01)
    else $error("startup bit not set");
  a_reg_readback: assert property (cfg_rd && known |=> cfg_rdata == $past(exp_rd))
    else $error("register read back differs from last write");
  a_reserved_zero: assert property (cfg_wr |->
    !(wr_thr && cfg_wdata[7:5] != 3'h0) && !(wr_cfg && cfg_wdata[7:4] != 4'h0))
    else $error("reserved bits written nonzero");
  a_thresh_link_off: assert property (wr_thr |-> !link_reg)
    else $error("threshold written with link enabled");
  a_host_waits: assert property ((cfg_wr || cfg_rd) && !done_reg |->
    rd_init || (cfg_wr && cfg_addr == `SRO_OFS_SOFT_RESET))
    else $error("access before startup finished");
  a_auto_zero: assert property ($rose(done_reg) |-> ##[0:20] s_zero_written)
    else $error("threshold not set to zero after startup");
endmodule // sro_monitor

/* verif/tb_top.sv */
// tb_top.sv: self-checking bench for host and device joined by the link
// assumes: design files and sro_monitor compiled before it
`timescale 1ns/1ps
`include "sro_consts.svh"
// ==========================================================
// bench top
module tb_top;
  logic clk;
  logic rst;
  logic [3:0][11:0] sample;
  logic [3:0] sw_addr;
  logic [15:0] sw_wdata;
  logic sw_wr;
  logic sw_rd;
  logic cmp_flag;
  logic cmp_q;
  logic [15:0] sw_rdata;
  logic sync_request;
  logic irq;
  logic [15:0] exp_q[$];
  string name_q[$];
  int sync_hi;
  int fails;
  int checked;
  integer seed;
  logic [11:0] ra [5] = '{12'h211, 12'h213, 12'h29A, 12'h2F1, 12'h100};
  logic [7:0] rv [5] = '{8'hF2, 8'h07, 8'h0F, 8'h00, 8'h00};
  logic [7:0] tv [3] = '{8'h00, 8'h02, 8'h1F};
  sro_link_if i_sro_link_if ();
  wire [3:0] ovr = {i_sro_link_if.overrange_out_d, i_sro_link_if.overrange_out_c,
    i_sro_link_if.overrange_out_b, i_sro_link_if.overrange_out_a};
  sro_device i_sro_device (.link(i_sro_link_if.dev), .clk(clk), .rst(rst), .sample(sample),
    .sync_request(sync_request), .irq(irq));
  sro_host i_sro_host (.link(i_sro_link_if.host), .clk(clk), .rst(rst), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  sro_monitor i_sro_monitor (.clk(clk), .rst(rst), .cfg_addr(i_sro_link_if.cfg_addr),
    .cfg_wdata(i_sro_link_if.cfg_wdata), .cfg_wr(i_sro_link_if.cfg_wr), .cfg_rd(i_sro_link_if.cfg_rd),
    .cfg_rdata(i_sro_link_if.cfg_rdata), .sync_n(i_sro_link_if.sync_n), .sync_request(sync_request),
    .overrange_out_a(ovr[0]), .overrange_out_b(ovr[1]), .overrange_out_c(ovr[2]),
    .overrange_out_d(ovr[3]));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ==========================================================
  // tasks
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic sw_wr_t(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_rd_t(logic [3:0] a, logic c, output logic [15:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    cmp_flag <= c;
    @(posedge clk);
    sw_rd <= 1'b0;
    @(negedge clk);
    d = sw_rdata;
  endtask
  task automatic note(logic [15:0] e, string nm);
    exp_q.push_back(e);
    name_q.push_back(nm);
  endtask
  // busy polling reads are not compared, only bounded
  task automatic wait_idle();
    logic [15:0] s;
    s = 16'h0001;
    for (int i = 0; i < 30 && s[0] !== 1'b0; i++) sw_rd_t(`SRO_H_STATUS, 1'b0, s);
    if (s[0] !== 1'b0) chk("host busy", 16'h0000, s);
  endtask
  task automatic dev_wr(logic [11:0] a, logic [7:0] d);
    sw_wr_t(`SRO_H_ADDR, {4'h0, a});
    sw_wr_t(`SRO_H_WDATA, {8'h00, d});
    sw_wr_t(`SRO_H_CMD, 16'h0001);
    wait_idle();
  endtask
  task automatic dev_rd(logic [11:0] a, logic [7:0] e, string nm);
    logic [15:0] d;
    sw_wr_t(`SRO_H_ADDR, {4'h0, a});
    sw_wr_t(`SRO_H_CMD, 16'h0002);
    wait_idle();
    note({8'h00, e}, nm);
    sw_rd_t(`SRO_H_RDATA, 1'b1, d);
  endtask
  task automatic pulse(int ch, logic [11:0] v, logic [15:0] e);
    logic [15:0] c [4];
    c = '{default: 16'h0000};
    @(posedge clk);
    sample[ch] <= v;
    @(posedge clk);
    sample[ch] <= 12'h000;
    repeat (40) begin
      @(negedge clk);
      for (int j = 0; j < 4; j++) c[j] += 16'(ovr[j]);
    end
    for (int j = 0; j < 4; j++) chk("pin high cycles", (j == ch) ? e : 16'h0000, c[j]);
  endtask
  // ==========================================================
  // result watcher: one note per compared read
  always @(posedge clk) cmp_q <= sw_rd && cmp_flag;
  always @(posedge clk) if (sync_request === 1'b1) sync_hi++;
  always @(negedge clk) begin
    if (cmp_q === 1'b1) chk(name_q.pop_front(), exp_q.pop_front(), sw_rdata);
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up();
  end
  // ==========================================================
  // main sequence
  initial begin
    logic [15:0] d;
    logic [7:0] lvl;
    logic [11:0] hit;
    int n;
    seed = 32'hb37f_16b0;
    rst = 1'b1;
    sample = '0;
    sw_addr = 4'h0;
    sw_wdata = 16'h0000;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    cmp_flag = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    d = 16'h0000;
    for (int i = 0; i < 60 && d[1] !== 1'b1; i++) sw_rd_t(`SRO_H_STATUS, 1'b0, d);
    chk("init seen", 16'h0002, d & 16'h0002);
    wait_idle();
    dev_rd(`SRO_OFS_SYNC_LIMIT, 8'h00, "threshold");
    dev_rd(`SRO_OFS_IRQ_STATUS, 8'h04, "irq status");
    dev_wr(12'h100, 8'h55);
    foreach (ra[i]) dev_rd(ra[i], rv[i], "reset value");
    lvl = 8'($random(seed));
    dev_wr(`SRO_OFS_POWER2, lvl);
    dev_rd(`SRO_OFS_POWER2, lvl, "power mode");
    $display("test registers done");
    dev_wr(`SRO_OFS_IRQ_MASK, 8'h01);
    foreach (tv[i]) begin
      dev_wr(`SRO_OFS_SYNC_LIMIT, tv[i]);
      dev_rd(`SRO_OFS_SYNC_LIMIT, tv[i], "threshold");
      for (int k = 0; k < 2; k++) begin
        n = sync_hi;
        sw_wr_t(`SRO_H_SYNC_LEN, 16'(tv[i]) + 16'(k));
        sw_wr_t(`SRO_H_CMD, 16'h0004);
        repeat (45) @(negedge clk);
        chk("sync request", 16'(k), 16'(sync_hi != n));
        chk("irq level", 16'(k), {15'h0000, irq});
        dev_rd(`SRO_OFS_IRQ_STATUS, 8'(k), "irq status");
      end
    end
    $display("test sync threshold done");
    dev_wr(`SRO_OFS_LINK_EN, 8'h01);
    sw_wr_t(`SRO_H_ADDR, {4'h0, `SRO_OFS_SYNC_LIMIT});
    sw_wr_t(`SRO_H_WDATA, 16'h0005);
    sw_wr_t(`SRO_H_CMD, 16'h0001);
    repeat (4) @(posedge clk);
    note(16'h0006, "host status");
    sw_rd_t(`SRO_H_STATUS, 1'b1, d);
    dev_rd(`SRO_OFS_SYNC_LIMIT, 8'h1F, "threshold kept");
    dev_wr(`SRO_OFS_LINK_EN, 8'h00);
    $display("test refused write done");
    lvl = 8'h20 + 8'($random(seed) & 32'h0000_007F);
    hit = {1'b0, lvl, 3'h0};
    dev_wr(`SRO_OFS_OVR_LEVEL, lvl);
    pulse(0, hit, 16'h0000);
    for (int e = 0; e < 3; e += 2) begin
      dev_wr(`SRO_OFS_OVR_CONFIG, 8'h08 | 8'(e));
      for (int ch = 0; ch < 4; ch++) begin
        pulse(ch, hit, 16'h0004 << e);
        pulse(ch, hit - 12'h001, 16'h0000);
        pulse(ch, 12'h000 - hit, 16'h0004 << e);
      end
    end
    dev_rd(`SRO_OFS_IRQ_STATUS, 8'h02, "irq status");
    dev_rd(`SRO_OFS_STARTUP, 8'h01, "startup");
    $display("test over-range done");
    wrap_up();
  end
endmodule // tb_top
